/* rtl/i2c_target_pkg.sv */
// constants and state type shared by the two-wire target port
package i2c_target_pkg;

    // fixed upper five bits of the seven-bit target address
    localparam logic [4:0] FIXED_ADDR_PART = 5'h14;

    // register offset of the sample buffer read port
    localparam logic [7:0] SAMPLE_PORT_OFFSET = 8'h08;

    // pointer value after a plain start followed by a read address
    localparam logic [7:0] PTR_RESET_VALUE = 8'h00;

    // one byte on the wire is eight data bits
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // falling edge that ends the last transmitted data bit
    localparam logic [3:0] TX_LAST_BIT = 4'h7;

    localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;

    localparam logic [3:0] BIT_COUNT_STEP = 4'h1;

    localparam logic [7:0] PTR_STEP = 8'h01;

    // pin function select: bit 0 set means output or special function
    localparam int MODE_DRIVEN_BIT = 0;

    // position of the direction bit in the address byte
    localparam int RW_BIT = 0;

    // the pin synchroniser holds three stages
    localparam int SYNC_STAGES = 3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_IGNORE
    } link_state_e;

endpackage

/* rtl/pin_events_if.sv */
// bus pin levels and condition events passed from the detector to the port
`timescale 1ns/100ps

interface pin_events_if;
    logic scl_level;
    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sel_low_level;
    logic sel_high_level;

    modport producer (
        output scl_level,
        output sda_level,
        output scl_rise,
        output scl_fall,
        output start_seen,
        output stop_seen,
        output sel_low_level,
        output sel_high_level
    );

    modport consumer (
        input  scl_level,
        input  sda_level,
        input  scl_rise,
        input  scl_fall,
        input  start_seen,
        input  stop_seen,
        input  sel_low_level,
        input  sel_high_level
    );
endinterface

/* rtl/bus_condition_detector.sv */
// synchronises the bus and select pins and flags clock edges, start and stop
`timescale 1ns/100ps

module bus_condition_detector (
    input  wire logic          mclk_in,
    input  wire logic          rst_in,
    input  wire logic          scl_in,
    input  wire logic          sda_in,
    input  wire logic          sel_low_in,
    input  wire logic          sel_high_in,
    pin_events_if.producer     ev
);

    localparam int NPINS = 4;

    logic [NPINS-1:0] raw;
    logic [NPINS-1:0] filt_q;
    logic [NPINS-1:0] prev_q;

    assign raw = {sel_high_in, sel_low_in, sda_in, scl_in};

    // each pin: three stages, a change is taken once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NPINS; g++)
        begin : g_sync
            logic [i2c_target_pkg::SYNC_STAGES-1:0] st_q;

            always_ff @(posedge mclk_in)
            begin
                if (rst_in)
                begin
                    st_q      <= '1;
                    filt_q[g] <= 1'b1;
                    prev_q[g] <= 1'b1;
                end
                else
                begin
                    st_q <= {st_q[i2c_target_pkg::SYNC_STAGES-2:0], raw[g]};
                    if (st_q[1] == st_q[2])
                    begin
                        filt_q[g] <= st_q[2];
                    end
                    prev_q[g] <= filt_q[g];
                end
            end
        end
    endgenerate

    assign ev.scl_level      = filt_q[0];
    assign ev.sda_level      = filt_q[1];
    assign ev.sel_low_level  = filt_q[2];
    assign ev.sel_high_level = filt_q[3];
    assign ev.scl_rise       = filt_q[0] & ~prev_q[0];
    assign ev.scl_fall       = ~filt_q[0] & prev_q[0];
    // a data change with the clock held high is a condition, not a bit
    assign ev.start_seen     = prev_q[1] & ~filt_q[1] & filt_q[0] & prev_q[0]; // see RULE3 RULE4
    assign ev.stop_seen      = ~prev_q[1] & filt_q[1] & filt_q[0] & prev_q[0]; // see RULE3 RULE4

endmodule // bus_condition_detector

/* rtl/i2c_target_register_port.sv */
// two-wire target port: address match, acknowledge, register pointer, sample reads
//
// How it works
// RULE1 - controller keeps the serial clock at 400kHz or below
// RULE2 - eight data bits then a ninth acknowledge pulse
// RULE3 - data changes only while clock is low
// RULE4 - start opens, stop releases, repeated start continues
// RULE5 - stop anywhere aborts the current transaction
// RULE6 - controller never stops in the start's clock-high
// RULE7 - received byte acknowledged low for whole ninth pulse
// RULE8 - read address acknowledged low on ninth pulse
// RULE9 - controller acks all read bytes, nacks last, stops
// RULE10 - write: start, address, pointer byte, data, stop
// RULE11 - pointer advances after each stored data byte
// RULE12 - no pointer advance when writing the sample port
// RULE13 - plain start with read address clears pointer
// RULE14 - read advances pointer, except at sample port
// RULE15 - set pointer by write, repeated start, then read
// RULE16 - transmitted bits shift out, valid at rising clock
// RULE17 - data line open-drain only, clock only an input
// RULE18 - sample words are two bytes from sample port
// RULE19 - address is 10100, two select pins, direction bit
// RULE20 - driven or special-function select pin reads as zero
// RULE21 - upper byte first, buffer advances after both bytes
// RULE22 - address mismatch: no ack, ignore until next start
// RULE23 - eight-bit pointer, loaded by first byte, wraps
`timescale 1ns/100ps

module i2c_target_register_port (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_out,
    input  wire logic        addr_select_pin_low_in,
    input  wire logic        addr_select_pin_high_in,
    input  wire logic [1:0]  pin_function_select_low_in,
    input  wire logic [1:0]  pin_function_select_high_in,
    output logic [7:0]       reg_addr_out,
    output logic             reg_wr_out,
    output logic [7:0]       reg_wr_data_out,
    output logic             reg_rd_out,
    input  wire logic [7:0]  reg_rd_data_in,
    input  wire logic [15:0] sample_word_in,
    output logic             sample_pop_out,
    output logic             busy_out
);

    pin_events_if ev ();
    i2c_target_pkg::link_state_e state_q;

    logic [3:0] bit_cnt_q;
    logic [7:0] rx_shift_q, tx_shift_q, ptr_q, reg_wr_data_q;
    logic [6:0] own_addr_q;
    logic       rw_q, first_byte_q, data_byte_q, nack_q, bus_active_q, repeated_q;
    logic       word_low_q, sda_oe_q, sda_o_q, reg_wr_q, reg_rd_q, pop_q, busy_q;

    logic       addr_done, addr_hit, rx_done, rx_ack_end, load_tx, tx_done;
    logic       tx_shift_fall, at_sample_port, addr_bit_low, addr_bit_high;
    logic [7:0] tx_byte;

    // the clock is only sampled; it is never driven back
    bus_condition_detector u_detect (
        .mclk_in     (mclk_in),
        .rst_in      (rst_in),
        .scl_in      (scl_in), // see RULE17
        .sda_in      (sda_in),
        .sel_low_in  (addr_select_pin_low_in),
        .sel_high_in (addr_select_pin_high_in),
        .ev          (ev)
    );

    assign at_sample_port = (ptr_q == i2c_target_pkg::SAMPLE_PORT_OFFSET);
    // a select pin in output or special function contributes a zero
    assign addr_bit_low  = ev.sel_low_level &
                           ~pin_function_select_low_in[i2c_target_pkg::MODE_DRIVEN_BIT];   // see RULE20
    assign addr_bit_high = ev.sel_high_level &
                           ~pin_function_select_high_in[i2c_target_pkg::MODE_DRIVEN_BIT];  // see RULE20
    assign addr_hit = (rx_shift_q[7:1] == own_addr_q);
    assign addr_done = (state_q == i2c_target_pkg::ST_ADDR) && ev.scl_fall &&
                       (bit_cnt_q == i2c_target_pkg::BITS_PER_BYTE);                      // see RULE2
    assign rx_done = (state_q == i2c_target_pkg::ST_RX) && ev.scl_fall &&
                     (bit_cnt_q == i2c_target_pkg::BITS_PER_BYTE);                        // see RULE2
    assign rx_ack_end = (state_q == i2c_target_pkg::ST_RX_ACK) && ev.scl_fall;
    assign load_tx = ev.scl_fall &&
                     (((state_q == i2c_target_pkg::ST_ADDR_ACK) && rw_q) ||
                      ((state_q == i2c_target_pkg::ST_TX_ACK) && !nack_q));                // see RULE9
    assign tx_shift_fall = (state_q == i2c_target_pkg::ST_TX) && ev.scl_fall;
    assign tx_done = tx_shift_fall && (bit_cnt_q == i2c_target_pkg::TX_LAST_BIT);

    // the sample port hands out the upper byte first, then the lower
    assign tx_byte = at_sample_port ? (word_low_q ? sample_word_in[7:0]
                                                  : sample_word_in[15:8])                // see RULE21
                                    : reg_rd_data_in;

    // protocol sequencer; start and stop take over from any state
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            state_q   <= i2c_target_pkg::ST_IDLE;
            bit_cnt_q <= i2c_target_pkg::BIT_COUNT_ZERO;
        end
        else if (ev.start_seen)
        begin
            state_q   <= i2c_target_pkg::ST_ADDR;                                         // see RULE4
            bit_cnt_q <= i2c_target_pkg::BIT_COUNT_ZERO;
        end
        else if (ev.stop_seen)
        begin
            state_q   <= i2c_target_pkg::ST_IDLE;                                         // see RULE5
            bit_cnt_q <= i2c_target_pkg::BIT_COUNT_ZERO;
        end
        else
        begin
            case (state_q)
                i2c_target_pkg::ST_ADDR,
                i2c_target_pkg::ST_RX:
                begin
                    if (ev.scl_rise)
                    begin
                        bit_cnt_q <= bit_cnt_q + i2c_target_pkg::BIT_COUNT_STEP;
                    end
                    if (addr_done)
                    begin
                        state_q <= addr_hit ? i2c_target_pkg::ST_ADDR_ACK
                                            : i2c_target_pkg::ST_IGNORE;                  // see RULE22
                    end
                    if (rx_done)
                    begin
                        state_q <= i2c_target_pkg::ST_RX_ACK;
                    end
                end
                i2c_target_pkg::ST_ADDR_ACK,
                i2c_target_pkg::ST_RX_ACK:
                begin
                    if (ev.scl_fall)
                    begin
                        state_q   <= ((state_q == i2c_target_pkg::ST_ADDR_ACK) && rw_q) ?
                                     i2c_target_pkg::ST_TX : i2c_target_pkg::ST_RX;  // see RULE10
                        bit_cnt_q <= i2c_target_pkg::BIT_COUNT_ZERO;
                    end
                end
                i2c_target_pkg::ST_TX:
                begin
                    if (tx_done)
                    begin
                        state_q <= i2c_target_pkg::ST_TX_ACK;
                    end
                    else if (tx_shift_fall)
                    begin
                        bit_cnt_q <= bit_cnt_q + i2c_target_pkg::BIT_COUNT_STEP;
                    end
                end
                i2c_target_pkg::ST_TX_ACK:
                begin
                    if (ev.scl_fall)
                    begin
                        // a not-acknowledge ends the read; wait for stop or start
                        state_q   <= nack_q ? i2c_target_pkg::ST_IGNORE
                                            : i2c_target_pkg::ST_TX;                      // see RULE9
                        bit_cnt_q <= i2c_target_pkg::BIT_COUNT_ZERO;
                    end
                end
                default: state_q <= state_q;
            endcase
        end
    end

    // own address is formed at every start from the select pins
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            own_addr_q   <= {i2c_target_pkg::FIXED_ADDR_PART, 2'h0};
            bus_active_q <= 1'b0;
            repeated_q   <= 1'b0;
        end
        else if (ev.start_seen)
        begin
            own_addr_q   <= {i2c_target_pkg::FIXED_ADDR_PART, addr_bit_high, addr_bit_low}; // see RULE19
            bus_active_q <= 1'b1;
            repeated_q   <= bus_active_q;                                                 // see RULE4
        end
        else if (ev.stop_seen)
        begin
            bus_active_q <= 1'b0;
            repeated_q   <= 1'b0;
        end
    end

    // serial input: bits are taken at the rising clock edge
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            rx_shift_q <= 8'h00;
            nack_q     <= 1'b0;
        end
        else
        begin
            if (ev.scl_rise && ((state_q == i2c_target_pkg::ST_ADDR) ||
                                (state_q == i2c_target_pkg::ST_RX)))
            begin
                rx_shift_q <= {rx_shift_q[6:0], ev.sda_level};                            // see RULE2
            end
            if (ev.scl_rise && (state_q == i2c_target_pkg::ST_TX_ACK))
            begin
                nack_q <= ev.sda_level;
            end
        end
    end

    // transaction flags: direction, pointer byte pending, data byte stored
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            rw_q         <= 1'b0;
            first_byte_q <= 1'b0;
            data_byte_q  <= 1'b0;
        end
        else
        begin
            if (addr_done)
            begin
                rw_q         <= rx_shift_q[i2c_target_pkg::RW_BIT];
                first_byte_q <= 1'b1;                                                     // see RULE10
            end
            if (rx_done)
            begin
                first_byte_q <= 1'b0;
                data_byte_q  <= !first_byte_q;
            end
        end
    end

    // register pointer: load, clear on plain-start read, advance with wrap
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ptr_q <= i2c_target_pkg::PTR_RESET_VALUE;
        end
        else if (addr_done && addr_hit && rx_shift_q[i2c_target_pkg::RW_BIT] && !repeated_q)
        begin
            ptr_q <= i2c_target_pkg::PTR_RESET_VALUE;                                     // see RULE13
        end
        else if (rx_done && first_byte_q)
        begin
            ptr_q <= rx_shift_q;                                                          // see RULE23 RULE15
        end
        else if (rx_ack_end && data_byte_q && !at_sample_port)
        begin
            ptr_q <= ptr_q + i2c_target_pkg::PTR_STEP;                                    // see RULE11 RULE12 RULE23
        end
        else if (tx_done && !at_sample_port)
        begin
            ptr_q <= ptr_q + i2c_target_pkg::PTR_STEP;                                    // see RULE14
        end
    end

    // data line driver: open drain, only ever pulls low
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            sda_oe_q   <= 1'b0;
            sda_o_q    <= 1'b0;
            tx_shift_q <= 8'h00;
        end
        else
        begin
            sda_o_q <= 1'b0;                                                              // see RULE17
            if (ev.start_seen || ev.stop_seen)
            begin
                sda_oe_q <= 1'b0;                                                         // see RULE5
            end
            else if (addr_done)
            begin
                sda_oe_q <= addr_hit;                                                     // see RULE8 RULE22
            end
            else if (rx_done)
            begin
                sda_oe_q <= 1'b1;                                                         // see RULE7
            end
            else if (load_tx)
            begin
                tx_shift_q <= tx_byte;
                sda_oe_q   <= ~tx_byte[7];                                                // see RULE16
            end
            else if (tx_done)
            begin
                sda_oe_q <= 1'b0;
            end
            else if (tx_shift_fall)
            begin
                tx_shift_q <= {tx_shift_q[6:0], 1'b0};
                sda_oe_q   <= ~tx_shift_q[6];                                             // see RULE16 RULE3
            end
            else if (ev.scl_fall && ((state_q == i2c_target_pkg::ST_ADDR_ACK) ||
                                     (state_q == i2c_target_pkg::ST_RX_ACK)))
            begin
                sda_oe_q <= 1'b0;                                                         // see RULE7
            end
        end
    end

    // sample port: word halves alternate, buffer pops after the lower byte
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            word_low_q <= 1'b0;
            pop_q      <= 1'b0;
        end
        else
        begin
            pop_q <= load_tx && at_sample_port && word_low_q;                             // see RULE21 RULE18
            if (ev.start_seen)
            begin
                word_low_q <= 1'b0;
            end
            else if (load_tx && at_sample_port)
            begin
                word_low_q <= !word_low_q;                                                // see RULE18
            end
        end
    end

    // register file strobes
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            reg_wr_q      <= 1'b0;
            reg_wr_data_q <= 8'h00;
            reg_rd_q      <= 1'b0;
            busy_q        <= 1'b0;
        end
        else
        begin
            reg_wr_q <= rx_done && !first_byte_q;                                         // see RULE11
            if (rx_done && !first_byte_q)
            begin
                reg_wr_data_q <= rx_shift_q;
            end
            reg_rd_q <= load_tx;
            busy_q   <= (state_q != i2c_target_pkg::ST_IDLE) &&
                        (state_q != i2c_target_pkg::ST_IGNORE);
        end
    end

    assign sda_out         = sda_o_q;
    assign sda_oe_out      = sda_oe_q;
    assign reg_addr_out    = ptr_q;
    assign reg_wr_out      = reg_wr_q;
    assign reg_wr_data_out = reg_wr_data_q;
    assign reg_rd_out      = reg_rd_q;
    assign sample_pop_out  = pop_q;
    assign busy_out        = busy_q;

endmodule // i2c_target_register_port

/* testbench/i2c_target_register_port_chk.sv */
// assertions on the two-wire target port pins and register strobes
`timescale 1ns/100ps
module i2c_target_register_port_chk (
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic [7:0] reg_addr_out,
    input wire logic       reg_wr_out,
    input wire logic [7:0] reg_wr_data_out,
    input wire logic       reg_rd_out,
    input wire logic       sample_pop_out,
    input wire logic       busy_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    // the ack spans a whole bus pulse, eight cycles is a cheap lower bound
    sequence ack_held;
        sda_oe_out [*8];
    endsequence
    sequence no_repeat(s);
        !s [*8];
    endsequence
    sda_low_only_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    data_steady_a: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_out))
        else $error("data drive changed while clock high");
    ack_write_a: assert property (reg_wr_out |-> ack_held)
        else $error("stored byte not acknowledged");
    wr_single_a: assert property (reg_wr_out |=> no_repeat(reg_wr_out))
        else $error("write strobe repeated");
    rd_single_a: assert property (reg_rd_out |=> no_repeat(reg_rd_out))
        else $error("read strobe repeated");
    pop_at_port_a: assert property (
        sample_pop_out |-> reg_rd_out && reg_addr_out == i2c_target_pkg::SAMPLE_PORT_OFFSET)
        else $error("sample pop away from the read port");
    wr_data_hold_a: assert property (!reg_wr_out |-> $stable(reg_wr_data_out))
        else $error("write data changed without strobe");
    strobe_busy_a: assert property ((reg_wr_out || reg_rd_out) |-> busy_out)
        else $error("strobe outside an addressed transfer");
endmodule // i2c_target_register_port_chk
bind i2c_target_register_port i2c_target_register_port_chk u_chk (
    .mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .reg_addr_out(reg_addr_out), .reg_wr_out(reg_wr_out),
    .reg_wr_data_out(reg_wr_data_out), .reg_rd_out(reg_rd_out),
    .sample_pop_out(sample_pop_out), .busy_out(busy_out));

/* testbench/i2c_controller_model.sv */
// bus controller model: starts, stops and bytes clocked from the link clock
`timescale 1ns/100ps
module i2c_controller_model #(
    parameter int QTR = 21
) (
    input  wire logic link_clk_in,
    input  wire logic sda_line_in,
    output logic      scl_out = 1'b1,
    output logic      sda_oe_out = 1'b0
);
    // a quarter bit of 21 link clocks keeps the bus clock below 400 kHz
    task automatic step(input logic c, input logic d);
        repeat (QTR) @(posedge link_clk_in);
        scl_out <= c;
        sda_oe_out <= d;
    endtask
    // works from idle and as a repeated start after an ack pulse
    task automatic start();
        step(scl_out, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, !b);
        step(1'b1, !b);
        step(1'b1, !b);
        r = sda_line_in;
        step(1'b0, !b);
    endtask
    // nack releases the ninth bit; acked reports a low ninth bit
    task automatic xfer(input logic [7:0] tx, input logic nack,
                        output logic [7:0] rx, output logic acked);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(nack, a);
        acked = !a;
    endtask
endmodule // i2c_controller_model

/* testbench/i2c_target_register_port_bench.sv */
// bench for the two-wire target port driven by a bus controller model
`timescale 1ns/100ps
module i2c_target_register_port_bench;
    logic        mclk_in = 1'b0;
    logic        link_clk = 1'b0;
    logic        rst_in = 1'b1;
    logic        sel_lo = 1'b1;
    logic        sel_hi = 1'b0;
    logic [1:0]  mode_lo = 2'h1;
    logic [1:0]  mode_hi = 2'h2;
    logic [15:0] word = 16'hC3E1;
    logic        scl, m_oe, sda_out, sda_oe, wr, rd, pop, busy, ack;
    logic [7:0]  ptr, wr_data, rx;
    logic [15:0] wr_log [$];
    int          n_fail = 0;
    int          n_compared = 0;
    // pull-up: the line is low while either side pulls it
    wire         sda_line = !(m_oe || sda_oe);
    // register contents follow the pointer combinationally
    wire [7:0]   rd_data = ptr ^ 8'h5A;
    always #2 mclk_in = !mclk_in;
    initial #7.3 forever #15 link_clk = !link_clk;
    i2c_target_register_port u_i2c_target_register_port (
        .mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_out(sda_oe), .addr_select_pin_low_in(sel_lo),
        .addr_select_pin_high_in(sel_hi), .pin_function_select_low_in(mode_lo),
        .pin_function_select_high_in(mode_hi), .reg_addr_out(ptr), .reg_wr_out(wr),
        .reg_wr_data_out(wr_data), .reg_rd_out(rd), .reg_rd_data_in(rd_data),
        .sample_word_in(word), .sample_pop_out(pop), .busy_out(busy));
    i2c_controller_model u_ctl (
        .link_clk_in(link_clk), .sda_line_in(sda_line), .scl_out(scl), .sda_oe_out(m_oe));
    always @(posedge mclk_in)
    begin
        if (pop)
            word <= word + 16'h0111;
        if (wr)
            wr_log.push_back({ptr, wr_data});
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic [7:0] b, input logic want);
        u_ctl.xfer(b, 1'b1, rx, ack);
        check("ack", ack, want);
    endtask
    task automatic rb(input logic last, input logic [7:0] exp);
        u_ctl.xfer(8'hFF, last, rx, ack);
        check("read byte", rx, exp);
    endtask
    task automatic t_write_wrap();
        logic b;
        u_ctl.start();
        wb(8'hA0, 1'b1);
        check("busy", busy, 1'b1);
        wb(8'hFF, 1'b1);
        wb(8'h5A, 1'b1);
        repeat (3) u_ctl.bit_io(1'b0, b);
        u_ctl.stop();
        repeat (8) @(posedge mclk_in);
        check("write", wr_log.pop_front(), 16'hFF5A);
        check("writes left", 16'(wr_log.size()), 16'h0000);
        check("pointer", ptr, 8'h00);
        check("idle", busy, 1'b0);
        $display("write_wrap done");
    endtask
    task automatic t_sample_read();
        u_ctl.start();
        wb(8'hA0, 1'b1);
        wb(8'h08, 1'b1);
        wb(8'h77, 1'b1);
        u_ctl.start();
        check("held pointer", ptr, 8'h08);
        check("write", wr_log.pop_front(), 16'h0877);
        wb(8'hA1, 1'b1);
        rb(1'b0, 8'hC3);
        rb(1'b0, 8'hE1);
        rb(1'b1, 8'hC4);
        u_ctl.stop();
        repeat (8) @(posedge mclk_in);
        check("one pop", word, 16'hC4F2);
        check("port pointer", ptr, 8'h08);
        $display("sample_read done");
    endtask
    task automatic t_addr_pins();
        @(posedge mclk_in);
        sel_hi <= 1'b1;
        mode_hi <= 2'h0;
        mode_lo <= 2'h3;
        u_ctl.start();
        wb(8'hA6, 1'b0);
        // a stop first, so that the read below follows a plain start
        u_ctl.stop();
        u_ctl.start();
        wb(8'hA5, 1'b1);
        rb(1'b1, 8'h5A);
        u_ctl.stop();
        repeat (8) @(posedge mclk_in);
        check("next pointer", ptr, 8'h01);
        check("idle", busy, 1'b0);
        $display("addr_pins done");
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        t_write_wrap();
        t_sample_read();
        t_addr_pins();
        give_verdict();
    end
    // the three tests need about 81000 cycles
    initial
    begin
        repeat (95000) @(posedge mclk_in);
        n_fail++;
        give_verdict();
    end
endmodule // i2c_target_register_port_bench
